//--- lcdg_core.sv
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module lcdg_core
  import lcdg_pkg::*;
(
  // clock, reset, freeze
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  // write address channel
  input  wire logic [LCDG_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // write data channel
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // write response channel
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // read address channel
  input  wire logic [LCDG_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // read data channel
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // line and frame timing
  output logic                        fetch_en,
  output logic                        line_blank,
  output logic                        line_start,
  output logic                        frame_start,
  output logic                        ac_drive,
  output logic [3:0]                  cell_row,
  // character geometry
  output logic                        text_vshift,
  output logic [8:0]                  scan_start_lines,
  output logic [4:0]                  cell_width,
  output logic [4:0]                  cell_height,
  output logic [1:0]                  cell_bytes,
  output logic                        char_gap,
  output logic [7:0]                  second_byte_mask
);

  // address decode shared by reads and writes
  function automatic lcdg_reg_t reg_decode(input logic [LCDG_ADDR_W-1:0] addr);
    unique case (addr)
      LCDG_OFS_MODE:   reg_decode = LCDG_R_MODE;
      LCDG_OFS_LINE:   reg_decode = LCDG_R_LINE;
      LCDG_OFS_VIRT:   reg_decode = LCDG_R_VIRT;
      LCDG_OFS_STATUS: reg_decode = LCDG_R_STATUS;
      default:         reg_decode = LCDG_R_NONE;
    endcase
  endfunction : reg_decode

  // visible pixels of the second byte, leftmost pixel in bit 7
  function automatic logic [7:0] pix_mask(input logic [4:0] width, input logic gap);
    logic [4:0] extra;
    extra = 5'h00;
    if (width > LCDG_BYTE_PIX && !gap) begin
      extra = width - LCDG_BYTE_PIX;
    end
    pix_mask = 8'hFF << (5'(LCDG_BYTE_PIX) - extra);
  endfunction : pix_mask

  localparam logic [31:0] CFG_MASK [LCDG_NUM_CFG] = '{LCDG_MASK_MODE, LCDG_MASK_LINE,
                                                     LCDG_MASK_VIRT};
  localparam logic [31:0] CFG_RST  [LCDG_NUM_CFG] = '{LCDG_RST_MODE, LCDG_RST_LINE,
                                                     LCDG_RST_VIRT};

  logic [31:0]            cfg [LCDG_NUM_CFG];
  logic                   aw_full;
  logic                   w_full;
  logic [LCDG_ADDR_W-1:0] aw_addr_q;
  logic [31:0]            w_data_q;
  logic [3:0]             w_strb_q;
  logic                   wr_fire;
  lcdg_reg_t              wr_reg;
  logic [7:0]             byte_cnt;
  logic [7:0]             line_cnt;
  logic [3:0]             ac_cnt;
  logic [7:0]             next_byte;
  logic [7:0]             next_line;
  logic                   line_end;
  logic                   frame_end;
  logic                   range_err;
  logic [31:0]            status_word;

  // parameter fields
  logic                   origin_comp_flag;
  logic                   ac_waveform_select;
  logic                   panel_dual;
  logic                   font_8px;
  logic [3:0]             char_width_field;
  logic [3:0]             char_height_field;
  logic [7:0]             disp_range;
  logic [7:0]             total_line_length;
  logic [7:0]             frame_lines;
  logic [15:0]            virt_range;

  assign origin_comp_flag   = cfg[0][LCDG_B_ORIGIN];
  assign ac_waveform_select = cfg[0][LCDG_B_WAVE];
  assign panel_dual         = cfg[0][LCDG_B_DUAL];
  assign font_8px           = cfg[0][LCDG_B_FONT8];
  assign char_width_field   = cfg[0][LCDG_F_WIDTH +: 4];
  assign char_height_field  = cfg[0][LCDG_F_HEIGHT +: 4];
  assign disp_range         = cfg[1][LCDG_F_RANGE +: 8];
  assign total_line_length  = cfg[1][LCDG_F_TOTAL +: 8];
  assign frame_lines        = cfg[1][LCDG_F_FRAME +: 8];
  assign virt_range         = cfg[2][15:0];

  // write commits once address and data are both held
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign wr_reg  = reg_decode(aw_addr_q);

  // write channels: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= LCDG_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full       <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full       <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_reg == LCDG_R_NONE) ? LCDG_RESP_SLVERR : LCDG_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // each parameter byte lands on its own strobe; untouched bytes keep their value
  for (genvar r = 0; r < LCDG_NUM_CFG; r++) begin : g_reg
    for (genvar b = 0; b < 4; b++) begin : g_lane
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg[r][8*b +: 8] <= CFG_RST[r][8*b +: 8];
        end else if (ce && wr_fire && wr_reg == lcdg_reg_t'(r) && w_strb_q[b]) begin
          cfg[r][8*b +: 8] <= w_data_q[8*b +: 8] & CFG_MASK[r][8*b +: 8];
        end
      end
    end
  end

  // live state for software; a range over the virtual width is flagged
  always_comb begin
    status_word                       = '0;
    status_word[LCDG_S_BYTE +: 8]     = byte_cnt;
    status_word[LCDG_S_LINE +: 8]     = line_cnt;
    status_word[LCDG_S_AC]            = ac_drive;
    status_word[LCDG_S_FETCH]         = fetch_en;
    status_word[LCDG_S_RANGE]         = range_err;
    status_word[LCDG_S_START +: 9]    = scan_start_lines;
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= LCDG_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= LCDG_RESP_OKAY;
        unique case (reg_decode(s_axi_araddr))
          LCDG_R_MODE:   s_axi_rdata <= cfg[0];
          LCDG_R_LINE:   s_axi_rdata <= cfg[1];
          LCDG_R_VIRT:   s_axi_rdata <= cfg[2];
          LCDG_R_STATUS: s_axi_rdata <= status_word;
          LCDG_R_NONE: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= LCDG_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // counters compare with >= so a shortened setting cannot strand them past the end
  assign line_end  = (byte_cnt >= total_line_length);
  assign frame_end = line_end && (line_cnt >= frame_lines);
  assign next_byte = line_end ? 8'h00 : byte_cnt + 8'h01;
  assign next_line = frame_end ? 8'h00 : (line_end ? line_cnt + 8'h01 : line_cnt);
  // the range may not pass the virtual width; the device blanks past what is shown
  assign range_err = ({8'h00, disp_range} > virt_range);

  // byte-period and line counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_cnt <= '0;
      line_cnt <= '0;
    end else if (ce) begin
      byte_cnt <= next_byte;
      line_cnt <= next_line;
    end
  end

  // fetch during the displayed range, blank the rest of the line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_en    <= 1'b0;
      line_blank  <= 1'b1;
      line_start  <= 1'b0;
      frame_start <= 1'b0;
    end else if (ce) begin
      fetch_en    <= (next_byte <= disp_range);
      line_blank  <= (next_byte > disp_range);
      line_start  <= line_end;
      frame_start <= frame_end;
    end
  end

  // ac polarity; the 16-line count runs on across frames so spacing stays even
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ac_cnt   <= '0;
      ac_drive <= 1'b0;
    end else if (ce) begin
      if (line_end) begin
        ac_cnt <= ac_cnt + 4'h1;
      end
      if (ac_waveform_select) begin
        if (frame_end) begin
          ac_drive <= !ac_drive;
        end
      end else if (line_end && ac_cnt == LCDG_AC_LAST) begin
        ac_drive <= !ac_drive;
      end
    end
  end

  // pixel row inside the character cell, restarted every frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cell_row <= '0;
    end else if (ce) begin
      if (frame_end || (line_end && cell_row >= char_height_field)) begin
        cell_row <= '0;
      end else if (line_end) begin
        cell_row <= cell_row + 4'h1;
      end
    end
  end

  // origin correction and scan start lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      text_vshift      <= 1'b0;
      scan_start_lines <= '0;
    end else if (ce) begin
      text_vshift <= !origin_comp_flag;
      if (panel_dual) begin
        scan_start_lines <= {2'b00, frame_lines[7:1]};
      end else begin
        scan_start_lines <= {1'b0, frame_lines} + {8'h00, !origin_comp_flag};
      end
    end
  end

  // cell geometry; a gap costs no extra byte, the second byte is simply dark
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cell_width       <= '0;
      cell_height      <= '0;
      cell_bytes       <= '0;
      char_gap         <= 1'b0;
      second_byte_mask <= '0;
    end else if (ce) begin
      cell_width       <= {1'b0, char_width_field} + 5'h01;
      cell_height      <= {1'b0, char_height_field} + 5'h01;
      cell_bytes       <= (char_width_field[3]) ? 2'h2 : 2'h1;
      char_gap         <= char_width_field[3] && font_8px;
      second_byte_mask <= pix_mask({1'b0, char_width_field} + 5'h01,
                                   char_width_field[3] && font_8px);
    end
  end

endmodule : lcdg_core

//--- lcdg_core_checker.sv
`timescale 1ns/1ps
module lcdg_core_checker (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // line timing and geometry
  input wire logic       fetch_en,
  input wire logic       line_blank,
  input wire logic       line_start,
  input wire logic       frame_start,
  input wire logic [4:0] cell_width,
  input wire logic [1:0] cell_bytes
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the bench lowers clock enable only while the bus is idle, so the bus figures are exact
  // both words are held one edge after the take, the answer rises on the edge after that
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write taken early");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready) else $error("write channel not freed");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  blank_inv_a: assert property (line_blank != fetch_en)
    else $error("blank and fetch overlap");
  // a legal line is at least five byte periods long
  line_gap_a: assert property (line_start |=> !line_start [*4])
    else $error("line too short");
  frame_line_a: assert property (frame_start |-> line_start)
    else $error("frame start off a line start");
  bytes_width_a: assert property ((cell_bytes == 2'h2) == (cell_width > 5'h08))
    else $error("byte count disagrees with width");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (frame_start);
endmodule : lcdg_core_checker

//--- lcdg_host.sv
`timescale 1ns/1ps
module lcdg_host (
  // clock
  input  wire logic        aclk,
  // write channels
  output logic [3:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // read channels
  output logic [3:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // idle bus before the first transfer
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
  end
  // one parameter word per write; strobe lanes pick the parameter bytes
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!done) begin
      @(posedge aclk);
      // released lines show a changed value, never the stale one
      if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    end while (!(s_axi_rvalid && s_axi_rready));
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : lcdg_host

//--- lcdg_pkg.sv
package lcdg_pkg;

  // register byte addresses
  localparam logic [3:0] LCDG_OFS_MODE   = 4'h0;
  localparam logic [3:0] LCDG_OFS_LINE   = 4'h4;
  localparam logic [3:0] LCDG_OFS_VIRT   = 4'h8;
  localparam logic [3:0] LCDG_OFS_STATUS = 4'hC;
  localparam int         LCDG_NUM_CFG    = 3;
  localparam int         LCDG_ADDR_W     = 4;

  // mode word fields
  localparam int LCDG_B_ORIGIN = 0;
  localparam int LCDG_B_WAVE   = 1;
  localparam int LCDG_B_DUAL   = 2;
  localparam int LCDG_B_FONT8  = 3;
  localparam int LCDG_F_WIDTH  = 8;
  localparam int LCDG_F_HEIGHT = 16;

  // line word fields
  localparam int LCDG_F_RANGE  = 0;
  localparam int LCDG_F_TOTAL  = 8;
  localparam int LCDG_F_FRAME  = 16;

  // status word fields
  localparam int LCDG_S_BYTE   = 0;
  localparam int LCDG_S_LINE   = 8;
  localparam int LCDG_S_AC     = 16;
  localparam int LCDG_S_FETCH  = 17;
  localparam int LCDG_S_RANGE  = 18;
  localparam int LCDG_S_START  = 20;

  // writable bits per register, reserved bits read as zero
  localparam logic [31:0] LCDG_MASK_MODE = 32'h000F_0F0F;
  localparam logic [31:0] LCDG_MASK_LINE = 32'h00FF_FFFF;
  localparam logic [31:0] LCDG_MASK_VIRT = 32'h0000_FFFF;

  // reset values: origin and waveform flags 1, 8x8 cells, 40 bytes shown of 48, 64 lines
  localparam logic [31:0] LCDG_RST_MODE  = 32'h0007_0703;
  localparam logic [31:0] LCDG_RST_LINE  = 32'h003F_2F27;
  localparam logic [31:0] LCDG_RST_VIRT  = 32'h0000_0028;

  // timing figures
  localparam logic [3:0]  LCDG_AC_LAST   = 4'hF;
  localparam logic [4:0]  LCDG_BYTE_PIX  = 5'h08;
  localparam logic [4:0]  LCDG_TWO_BYTES = 5'h10;

  // bus answer codes
  localparam logic [1:0]  LCDG_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  LCDG_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    LCDG_R_MODE   = 3'b000,
    LCDG_R_LINE   = 3'b001,
    LCDG_R_VIRT   = 3'b010,
    LCDG_R_STATUS = 3'b011,
    LCDG_R_NONE   = 3'b100
  } lcdg_reg_t;

endpackage : lcdg_pkg

//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import lcdg_pkg::*;
  logic        aclk, aresetn, ce, tg;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, cell_row;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, rdat, m;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, cell_bytes;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        fetch_en, line_blank, line_start, frame_start, ac_drive, text_vshift, char_gap;
  logic [8:0]  scan_start_lines;
  logic [4:0]  cell_width, cell_height, w;
  logic [7:0]  second_byte_mask, r, t, f;
  logic [31:0] rv [3];
  logic [31:0] corner [4];
  logic [6:0]  snap;
  int          fails = 0, n_checks = 0, n, e;

  lcdg_core u_lcdg_core (.*);
  lcdg_host u_lcdg_host (.*);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // watchdog well beyond the expected run of at most some 10000 cycles
  initial begin
    #400us;
    fails++;
    test_done();
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // visible pixels of the second byte, leftmost pixel in bit 7
  function automatic logic [7:0] exp_mask(input logic [4:0] cw, input logic gap);
    return (gap || cw <= 5'h08) ? 8'h00 : 8'hFF << (5'h10 - cw);
  endfunction : exp_mask
  // end of a span: next line, next frame, or a turn of the drive waveform
  function automatic bit stop(input int md, input logic a);
    return md == 0 ? line_start === 1'b1 : md == 1 ? frame_start === 1'b1 : ac_drive !== a;
  endfunction : stop
  task automatic test_done();
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // md 0 counts byte periods and fetches, otherwise counts line starts
  task automatic span(input int md, output int cnt, output int fc, output logic tgl);
    logic a;
    int   i;
    a = ac_drive;
    i = 0;
    do begin
      @(posedge aclk);
      i++;
    end while (!stop(md, a) && i < 5000);
    a = ac_drive;
    cnt = 0;
    fc = 0;
    do begin
      fc += int'(fetch_en === 1'b1);
      cnt += (md == 0) ? 1 : int'(line_start === 1'b1);
      @(posedge aclk);
    end while (!stop(md, a) && cnt < 600);
    tgl = (ac_drive !== a);
  endtask : span

  initial begin
    seed = 32'd84033;
    rv = '{LCDG_RST_MODE, LCDG_RST_LINE, LCDG_RST_VIRT};
    corner = '{32'h000F_0F08, 32'h0000_0801, 32'h0000_0705, 32'h0000_0C00};
    ce = 1'b1;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // parameter words come up with their reset values
    for (int i = 0; i < LCDG_NUM_CFG; i++) begin
      u_lcdg_host.rd(4'(4 * i), rdat, resp);
      `CHK(rdat, rv[i])
    end
    // unmapped places answer with an error
    u_lcdg_host.rd(4'h6, rdat, resp);
    `CHK(resp, LCDG_RESP_SLVERR)
    u_lcdg_host.wr(4'h2, 32'hFFFF_FFFF, 4'hF, resp);
    `CHK(resp, LCDG_RESP_SLVERR)
    // one parameter byte leaves its neighbours untouched
    u_lcdg_host.wr(LCDG_OFS_LINE, 32'hAAAA_AA05, 4'h1, resp);
    `CHK(resp, LCDG_RESP_OKAY)
    u_lcdg_host.rd(LCDG_OFS_LINE, rdat, resp);
    `CHK(rdat, {LCDG_RST_LINE[31:8], 8'h05})
    // cell geometry: corner words first, then random ones
    for (int k = 0; k < 28; k++) begin
      m = (k < 4) ? corner[k] : xs();
      u_lcdg_host.wr(LCDG_OFS_MODE, m, 4'hF, resp);
      repeat (2) @(posedge aclk);
      w = 5'(m[11:8]) + 5'h01;
      `CHK(cell_width, w)
      `CHK(cell_height, 5'(m[19:16]) + 5'h01)
      `CHK(cell_bytes, m[11] ? 2'h2 : 2'h1)
      `CHK(char_gap, m[11] & m[3])
      `CHK(second_byte_mask, exp_mask(w, m[11] & m[3]))
      `CHK(text_vshift, ~m[0])
      `CHK(scan_start_lines, m[2] ? 9'h01F : 9'h03F + 9'(!m[0]))
    end
    // line and frame timing under frame-by-frame drive
    u_lcdg_host.wr(LCDG_OFS_MODE, LCDG_RST_MODE, 4'hF, resp);
    for (int k = 0; k < 6; k++) begin
      r = (k == 0) ? 8'h00 : (k == 1) ? 8'h27 : 8'(xs() % 40);
      t = r + 8'h04 + ((k < 2) ? 8'h00 : 8'(xs() % 20));
      f = 8'(xs() % 6) + 8'h01;
      // virtual width matches the shown range, so the range flag stays clear
      u_lcdg_host.wr(LCDG_OFS_VIRT, {24'h00_0000, r} + 32'h0000_0001, 4'hF, resp);
      u_lcdg_host.wr(LCDG_OFS_LINE, {8'h00, f, t, r}, 4'hF, resp);
      span(0, n, e, tg);
      `CHK(n, int'(t) + 1)
      `CHK(e, int'(r) + 1)
      span(1, n, e, tg);
      `CHK(cell_row, 4'h0)
      `CHK(n, int'(f) + 1)
      `CHK(tg, 1'b1)
      `CHK(scan_start_lines, {1'b0, f})
    end
    // a virtual width below the shown range raises the status flag
    u_lcdg_host.wr(LCDG_OFS_VIRT, 32'h0000_0000, 4'hF, resp);
    u_lcdg_host.rd(LCDG_OFS_STATUS, rdat, resp);
    `CHK(rdat[LCDG_S_RANGE], r != 8'h00)
    `CHK(rdat[LCDG_S_START +: 9], {1'b0, f})
    // sixteen-line drive; the first turn may fall mid-count
    u_lcdg_host.wr(LCDG_OFS_MODE, 32'h0007_0701, 4'hF, resp);
    span(2, n, e, tg);
    span(2, n, e, tg);
    `CHK(n, 16)
    // low clock enable freezes the line timing; longer than any line of this run
    do @(posedge aclk); while (line_start !== 1'b1);
    ce <= 1'b0;
    @(posedge aclk);
    snap = {fetch_en, line_start, cell_row, ac_drive};
    n = 0;
    repeat (70) begin
      @(posedge aclk);
      n += int'(line_start === 1'b1);
    end
    `CHK(n, 0)
    `CHK({fetch_en, line_start, cell_row, ac_drive}, snap)
    ce <= 1'b1;
    test_done();
  end
endmodule : tb_top

bind lcdg_core lcdg_core_checker u_lcdg_core_checker (.*);
